// ---- rtl/sdct_core.v ----
// sdram command decode, burst and latency core
`include "sdct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sdct_core #(
	parameter COLW = 9,
	parameter DW   = 16
) (
	input  wire                clk,
	input  wire                rst_n,
	input  wire                cke,
	input  wire                cs_n,
	input  wire                ras_n,
	input  wire                cas_n,
	input  wire                we_n,
	input  wire                bank_select_bit0,
	input  wire                bank_select_bit1,
	input  wire [12:0]         addr,
	input  wire                low_byte_mask,
	input  wire                high_byte_mask,
	input  wire [DW-1:0]       dq_in,
	output wire [DW-1:0]       dq_out,
	output wire [DW-1:0]       dq_oe,
	output wire [COLW+1:0]     rd_addr,
	output wire                rd_addr_valid,
	input  wire [DW-1:0]       rd_word,
	output wire                wr_valid,
	input  wire                wr_ready,
	output wire [DW+COLW+3:0]  wr_word,
	output reg                 wr_overflow_r,
	output reg  [3:0]          bank_open_r,
	output reg  [2:0]          read_latency_setting_r,
	output reg  [2:0]          burst_count_r,
	output reg                 refresh_pulse_r,
	output reg                 mode_set_pulse_r,
	output reg                 self_refresh_r,
	output wire                power_down
);
	reg              cke_d_r;
	reg              rd_act_r;
	reg              wr_act_r;
	reg              ap_r;
	reg  [COLW:0]    left_r;
	reg  [COLW-1:0]  col_r;
	reg  [1:0]       bank_r;
	reg              p0_v_r;
	reg  [COLW+1:0]  p0_addr_r;
	reg              p1_v_r;
	reg  [DW-1:0]    p1_data_r;
	reg  [1:0]       mask_d_r;
	reg  [DW-1:0]    dq_out_r;
	reg  [1:0]       oe_r;

	wire             en;
	wire             cmd_v;
	wire [2:0]       cmd;
	wire [1:0]       bank;
	wire             c_act;
	wire             c_pre;
	wire             c_rd;
	wire             c_wr;
	wire             c_bst;
	wire             c_ref;
	wire             c_mrs;
	wire             col_cmd;
	wire             stop;
	wire             rd_beat;
	wire             wr_beat;
	wire [COLW-1:0]  beat_col;
	wire [1:0]       beat_bank;
	wire [COLW:0]    blen;
	wire [COLW:0]    left_nxt;
	wire [COLW-1:0]  wrap;
	wire [COLW-1:0]  col_nxt;
	wire             burst_end;
	wire             cl3;
	wire [DW-1:0]    out_src;
	wire             out_v;
	wire             buf_ready;
	wire [1:0]       wr_be;

	// burst length in beats for a mode register code
	function [COLW:0] bl_len;
		input [2:0] code;
		begin
			case (code)
				3'h0:         bl_len = {{COLW{1'b0}}, 1'b1};
				3'h1:         bl_len = {{(COLW-1){1'b0}}, 2'h2};
				3'h2:         bl_len = {{(COLW-2){1'b0}}, 3'h4};
				3'h3:         bl_len = {{(COLW-3){1'b0}}, 4'h8};
				`SDCT_BL_FULL: bl_len = {1'b1, {COLW{1'b0}}};
				default:      bl_len = {{COLW{1'b0}}, 1'b1};
			endcase
		end
	endfunction

	// internal clock runs on edges whose previous cke sample was high
	assign en         = cke_d_r;
	assign power_down = ~cke_d_r;

	// commands latch only while chip select is low
	assign cmd_v = en & ~cs_n;
	assign cmd   = {ras_n, cas_n, we_n};
	assign bank  = {bank_select_bit1, bank_select_bit0};

	// row strobe low, column high: write enable picks activate or precharge
	assign c_act = cmd_v & (cmd == `SDCT_CMD_ACT);
	assign c_pre = cmd_v & (cmd == `SDCT_CMD_PRE);
	assign c_rd  = cmd_v & (cmd == `SDCT_CMD_RD);
	assign c_wr  = cmd_v & (cmd == `SDCT_CMD_WR);
	assign c_bst = cmd_v & (cmd == `SDCT_CMD_BST);
	assign c_ref = cmd_v & (cmd == `SDCT_CMD_REF);
	assign c_mrs = cmd_v & (cmd == `SDCT_CMD_MRS);

	// a new column command simply replaces the running burst
	assign col_cmd = c_rd | c_wr;
	assign stop    = col_cmd | c_bst |
		(c_pre & (addr[`SDCT_A_AUTOPRE] | (bank == bank_r)));

	assign rd_beat   = c_rd | (en & rd_act_r & ~stop);
	assign wr_beat   = c_wr | (en & wr_act_r & ~stop);
	assign beat_col  = col_cmd ? addr[COLW-1:0] : col_r;
	assign beat_bank = col_cmd ? bank : bank_r;
	assign blen      = bl_len(burst_count_r);
	assign left_nxt  = (col_cmd ? blen : left_r) - {{COLW{1'b0}}, 1'b1};
	assign wrap      = blen[COLW-1:0] - {{(COLW-1){1'b0}}, 1'b1};
	assign col_nxt   = (beat_col & ~wrap) | ((beat_col + {{(COLW-1){1'b0}}, 1'b1}) & wrap);
	assign burst_end = (rd_beat | wr_beat) & (left_nxt == {(COLW+1){1'b0}});

	// write path: mask high blocks the word in the same cycle, per byte
	assign wr_be = ~{high_byte_mask, low_byte_mask};

	sdct_buf2 #(
		.W (DW + COLW + 4)
	) u_wbuf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (wr_beat & (wr_be != 2'h0)),
		.in_ready  (buf_ready),
		.in_data   ({beat_bank, beat_col, wr_be, dq_in}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_word)
	);

	// read path: stage 0 holds the address, rd_word comes back from storage
	assign cl3           = (read_latency_setting_r == `SDCT_CL_THREE);
	assign rd_addr       = p0_addr_r;
	assign rd_addr_valid = p0_v_r;
	assign out_src       = cl3 ? p1_data_r : rd_word;
	assign out_v         = cl3 ? p1_v_r : p0_v_r;
	assign dq_out        = dq_out_r;

	genvar g;
	generate
		for (g = 0; g < DW; g = g + 1) begin : g_oe
			assign dq_oe[g] = oe_r[(g * 2) / DW];
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cke_d_r <= 1'b1;
		end else begin
			cke_d_r <= cke;
		end
	end

	// command, burst and mode state; frozen while the internal clock stops, except that the pulses clear and self_refresh_r clears on cke high
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_act_r               <= 1'b0;
			wr_act_r               <= 1'b0;
			ap_r                   <= 1'b0;
			left_r                 <= {(COLW+1){1'b0}};
			col_r                  <= {COLW{1'b0}};
			bank_r                 <= 2'h0;
			bank_open_r            <= 4'h0;
			read_latency_setting_r <= `SDCT_CL_RESET;
			burst_count_r          <= `SDCT_BL_RESET;
			refresh_pulse_r        <= 1'b0;
			mode_set_pulse_r       <= 1'b0;
			self_refresh_r         <= 1'b0;
			wr_overflow_r          <= 1'b0;
		end else begin
			refresh_pulse_r  <= c_ref & cke;
			mode_set_pulse_r <= c_mrs;
			wr_overflow_r    <= wr_beat & (wr_be != 2'h0) & ~buf_ready;
			if (c_ref & ~cke)
				self_refresh_r <= 1'b1;
			else if (self_refresh_r & cke)
				self_refresh_r <= 1'b0;
			if (en) begin
				if (c_mrs) begin
					burst_count_r          <= addr[`SDCT_MR_BL_LO +: 3];
					read_latency_setting_r <= addr[`SDCT_MR_CL_LO +: 3];
				end
				if (col_cmd) begin
					ap_r   <= addr[`SDCT_A_AUTOPRE];
					bank_r <= bank;
				end else if (stop) begin
					ap_r <= 1'b0;
				end
				if (rd_beat | wr_beat) begin
					left_r <= left_nxt;
					col_r  <= col_nxt;
				end
				rd_act_r <= rd_beat & ~burst_end;
				wr_act_r <= wr_beat & ~burst_end;
				if (c_act)
					bank_open_r[bank] <= 1'b1;
				else if (c_pre & addr[`SDCT_A_AUTOPRE])
					bank_open_r <= 4'h0;
				else if (c_pre)
					bank_open_r[bank] <= 1'b0;
				if (burst_end & (col_cmd ? addr[`SDCT_A_AUTOPRE] : ap_r))
					bank_open_r[beat_bank] <= 1'b0;
			end
		end
	end

	// read pipeline: data valid at edge 3 after the beat for latency code 3, at edge 2 for any other code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p0_v_r    <= 1'b0;
			p0_addr_r <= {(COLW+2){1'b0}};
			p1_v_r    <= 1'b0;
			p1_data_r <= {DW{1'b0}};
			mask_d_r  <= 2'h3;
			dq_out_r  <= {DW{1'b0}};
			oe_r      <= 2'h0;
		end else if (en) begin
			p0_v_r    <= rd_beat;
			p0_addr_r <= {beat_bank, beat_col};
			p1_v_r    <= p0_v_r;
			p1_data_r <= rd_word;
			mask_d_r  <= {high_byte_mask, low_byte_mask};
			dq_out_r  <= out_src;
			// mask sampled one edge back turns the byte off at the next
			oe_r      <= {2{out_v}} & ~mask_d_r;
		end
	end
endmodule // sdct_core
`default_nettype wire

// ---- common/sdct_defs.vh ----
// constants for the sdram command timing core
`ifndef SDCT_DEFS_VH
`define SDCT_DEFS_VH

// command code {ras_n, cas_n, we_n}
`define SDCT_CMD_NOP   3'h7
`define SDCT_CMD_ACT   3'h3
`define SDCT_CMD_PRE   3'h2
`define SDCT_CMD_RD    3'h5
`define SDCT_CMD_WR    3'h4
`define SDCT_CMD_BST   3'h6
`define SDCT_CMD_REF   3'h1
`define SDCT_CMD_MRS   3'h0

// address fields
`define SDCT_A_AUTOPRE 10
`define SDCT_MR_BL_LO  0
`define SDCT_MR_CL_LO  4

// mode register reset values and codes
`define SDCT_BL_RESET  3'h0
`define SDCT_CL_RESET  3'h2
`define SDCT_CL_THREE  3'h3
`define SDCT_BL_FULL   3'h7

`endif

// ---- rtl/sdct_buf2.v ----
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module sdct_buf2 #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg  [W-1:0] mem_r [0:1];
	reg          rd_ptr_r;
	reg          wr_ptr_r;
	reg  [1:0]   count_r;
	wire         push;
	wire         pop;

	assign in_ready  = (count_r != 2'h2);
	assign out_valid = (count_r != 2'h0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

	always @(posedge clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end
endmodule // sdct_buf2
`default_nettype wire

// ---- verification/sdct_core_chk.sv ----
// assertion checker for the sdram command core
`timescale 1ns/1ps
`default_nettype none
module sdct_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        bank_select_bit0,
	input wire logic        bank_select_bit1,
	input wire logic [12:0] addr,
	input wire logic        low_byte_mask,
	input wire logic        high_byte_mask,
	input wire logic [15:0] dq_oe,
	input wire logic        rd_addr_valid,
	input wire logic        wr_valid,
	input wire logic [3:0]  bank_open_r,
	input wire logic [2:0]  read_latency_setting_r,
	input wire logic        refresh_pulse_r,
	input wire logic        power_down
);
	logic       ckq_r;
	wire  [2:0] cmd = {ras_n, cas_n, we_n};
	wire        tk  = ckq_r && !cs_n;
	wire        c2  = read_latency_setting_r != 3'h3;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) ckq_r <= 1'b1;
		else ckq_r <= cke;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_act_opens_bank: assert property (tk && cmd == 3'h3 |=>
		bank_open_r[$past({bank_select_bit1, bank_select_bit0})]) else $error("bank not opened");
	a_pre_all_close: assert property (tk && cmd == 3'h2 && addr[10] |=>
		bank_open_r == 4'h0) else $error("banks not closed");
	a_desel_ignored: assert property (cs_n |=> !refresh_pulse_r)
		else $error("deselected command taken");
	a_cke_latency: assert property (1'b1 |=> power_down == !$past(cke))
		else $error("clock enable latency wrong");
	a_rd_mask_float: assert property ($past(cke) && cke && low_byte_mask |=> ##1
		dq_oe[7:0] == 8'h00) else $error("masked byte still driven");
	a_wr_mask_drop: assert property (!wr_valid && tk && cmd == 3'h4 && low_byte_mask
		&& high_byte_mask |=> !wr_valid) else $error("masked write pushed");
	a_rd_beat_out: assert property (tk && cke && cmd == 3'h5 && c2 && !low_byte_mask
		&& !high_byte_mask |=> rd_addr_valid ##1 dq_oe == 16'hffff) else $error("read beat late");
	a_stop_float: assert property (tk && cke && c2 && (cmd == 3'h6 || cmd == 3'h2 && addr[10])
		|=> ##1 dq_oe == 16'h0000) else $error("outputs not floated");
endmodule // sdct_chk
bind sdct_core sdct_chk sdct_chk_inst (.clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
	.bank_select_bit0, .bank_select_bit1, .addr, .low_byte_mask, .high_byte_mask, .dq_oe,
	.rd_addr_valid, .wr_valid, .bank_open_r, .read_latency_setting_r, .refresh_pulse_r,
	.power_down);
`default_nettype wire

// ---- verification/sdct_store.sv ----
// storage model answering reads and taking write beats
`timescale 1ns/1ps
`default_nettype none
module sdct_store (
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic [10:0] rd_addr,
	output logic      [15:0] rd_word,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic [28:0] wr_word,
	output logic      [28:0] last_r,
	output int               cnt_r
);
	assign rd_word  = {rd_addr[4:0], rd_addr} ^ 16'h5a3c;
	assign wr_ready = !stall;
	initial cnt_r = 0;
	always @(posedge clk)
		if (wr_valid && wr_ready) begin
			last_r <= wr_word;
			cnt_r  <= cnt_r + 1;
		end
endmodule // sdct_store
`default_nettype wire

// ---- verification/sdct_core_tb_top.sv ----
// self-checking bench for the sdram command core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sdct_core_tb_top;
	logic        clk = 1'b0, rst_n = 1'b0, cke = 1'b1, cs_n = 1'b0, ras_n = 1'b1, cas_n = 1'b1;
	logic        we_n = 1'b1, bank_select_bit0 = 1'b0, bank_select_bit1 = 1'b0, stall = 1'b0;
	logic        low_byte_mask = 1'b0, high_byte_mask = 1'b0, ovf = 1'b0;
	logic [12:0] addr = 13'h0000;
	logic [15:0] dq_in = 16'h0000, lf = 16'h69d2, dq_out, dq_oe, rd_word, eo;
	logic [10:0] rd_addr;
	logic [28:0] wr_word, last;
	logic [3:0]  bank_open_r;
	logic [2:0]  read_latency_setting_r, burst_count_r;
	logic [1:0]  m;
	logic        rd_addr_valid, wr_valid, wr_ready, wr_overflow_r, refresh_pulse_r;
	logic        mode_set_pulse_r, power_down;
	int          err_count = 0, samples_checked = 0, cnt, c0;
	localparam int PAUSE = (200000 + 40 - 1) / 40;
	sdct_core sdct_core_inst (.clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select_bit0, .bank_select_bit1, .addr, .low_byte_mask, .high_byte_mask, .dq_in,
		.dq_out, .dq_oe, .rd_addr, .rd_addr_valid, .rd_word, .wr_valid, .wr_ready, .wr_word,
		.wr_overflow_r, .bank_open_r, .read_latency_setting_r, .burst_count_r,
		.refresh_pulse_r, .mode_set_pulse_r, .self_refresh_r(), .power_down);
	sdct_store sdct_store_inst (.clk, .stall, .rd_addr, .rd_word, .wr_valid, .wr_ready,
		.wr_word, .last_r(last), .cnt_r(cnt));
	always #20 clk = ~clk;
	always @(posedge clk) if (wr_overflow_r) ovf <= 1'b1;
	function automatic logic [15:0] ex(input logic [10:0] a);
		return {a[4:0], a} ^ 16'h5a3c;
	endfunction
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [3:0] c, input logic [12:0] a, input logic [1:0] mk);
		@(posedge clk);
		lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_bit1, bank_select_bit0, addr} <= {lf[1:0], a};
		{high_byte_mask, low_byte_mask, dq_in} <= {mk, lf};
		@(posedge clk);
		{cs_n, ras_n, cas_n, we_n, high_byte_mask, low_byte_mask} <= 6'h1c;
		#1;
	endtask
	initial begin
		#400000;
		err_count++;
		close_out;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		{high_byte_mask, low_byte_mask} <= 2'h3;
		repeat (PAUSE) @(posedge clk);
		cmd(4'h2, 13'h0400, 2'h3);
		cmd(4'h0, 13'h0020, 2'h0);
		`CHK({read_latency_setting_r, burst_count_r}, 6'h10)
		`CHK(mode_set_pulse_r, 1'b1)
		for (int i = 0; i < 8; i++) begin
			cmd(4'h1, 13'h0000, 2'h0);
			`CHK(refresh_pulse_r, 1'b1)
		end
		for (int i = 0; i < 4; i++) begin
			cmd(4'h3, 13'h0000, 2'h0);
			`CHK(bank_open_r[{bank_select_bit1, bank_select_bit0}], 1'b1)
		end
		for (int i = 0; i < 4; i++) begin
			c0 = cnt;
			cmd(4'h4, {4'h0, lf[8:0]}, i[1:0]);
			repeat (2) @(posedge clk);
			#1;
			`CHK(cnt - c0, int'(i < 3))
			if (i < 3) `CHK(last, {bank_select_bit1, bank_select_bit0, addr[8:0], ~i[1:0], dq_in})
		end
		$display("write test done");
		for (int i = 0; i < 12; i++) begin
			m = lf[3:2];
			eo = {{8{!m[1]}}, {8{!m[0]}}};
			cmd(4'h5, {4'h0, lf[8:0]}, m);
			@(posedge clk);
			#1;
			`CHK(dq_oe, eo)
			`CHK(dq_out & eo, ex({bank_select_bit1, bank_select_bit0, addr[8:0]}) & eo)
		end
		cmd(4'h0, 13'h0030, 2'h0);
		cmd(4'h5, 13'h0005, 2'h0);
		@(posedge clk);
		#1;
		`CHK(dq_oe, 16'h0000)
		@(posedge clk);
		#1;
		`CHK(dq_out, ex({bank_select_bit1, bank_select_bit0, 9'h005}))
		cmd(4'h0, 13'h0020, 2'h0);
		$display("read test done");
		for (int i = 0; i < 2; i++) begin
			cmd({i[0], 3'h1}, 13'h0000, 2'h0);
			`CHK(refresh_pulse_r, !i[0])
		end
		stall <= 1'b1;
		c0 = cnt;
		for (int i = 0; i < 3; i++) cmd(4'h4, 13'h0000, 2'h0);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		`CHK({ovf, 32'(cnt - c0)}, {1'b1, 32'h2})
		cke <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(power_down, 1'b1)
		cke <= 1'b1;
		cmd(4'h2, 13'h0400, 2'h0);
		`CHK(bank_open_r, 4'h0)
		$display("control test done");
		close_out;
	end
endmodule // sdct_core_tb_top
`default_nettype wire
